//--- core/gg_gauge_target.sv
// Module: two-wire target of the battery gauge with its pin straps and crossings
`timescale 1ns/1ns
`default_nettype none
module gg_gauge_target #(
   parameter logic [15:0] REVISION_CODE = 16'h0001  // Arbitrary value
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   input  wire logic        link_clk,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        osc_source_select_pin,
   input  wire logic        ext_clock_or_restart_pin,
   output logic [15:0]      model_compensation,
   output logic             quick_start,
   output logic             full_reset,
   output logic             ext_osc_selected,
   output logic             ext_clock_tick
);

   // ---------------- link domain ----------------
   logic [1:0]  lrst_r;
   logic        len_s1_r;
   logic        len_r;
   logic        scl_s1_r, scl_s2_r, scl_d_r;
   logic        sda_s1_r, sda_s2_r, sda_d_r;
   gg_pkg::gg_link_state_type state_r, state_nxt;
   logic [3:0]  bit_cnt_r;
   logic [7:0]  rx_sh_r;
   logic [7:0]  tx_sh_r;
   logic        is_id_r;
   logic        need_ptr_r;
   logic        rw_r;
   logic        ack_r;
   logic        m_ack_r;
   logic [7:0]  ptr_r;
   logic        past_top_r;
   logic [7:0]  hi_r;
   logic        hi_ok_r;
   logic        sda_oe_r;
   logic [7:0]  wr_addr_r;
   logic [15:0] wr_data_r;
   logic        wr_tgl_r;
   logic        rd_tgl_r;
   logic        ack_s1_r, ack_s2_r, ack_d_r;
   logic [7:0]  fetch_r;

   // ---------------- main domain ----------------
   logic        wr_s1_r, wr_s2_r, wr_d_r;
   logic        rd_s1_r, rd_s2_r, rd_d_r;
   logic [1:0]  rd_pipe_r;
   logic [7:0]  rd_addr_m_r;
   logic [7:0]  rd_byte_m_r;
   logic        ack_tgl_r;
   logic        wr_pulse_r;
   logic [7:0]  wr_addr_m_r;
   logic [15:0] wr_data_m_r;
   logic        osc_s1_r, osc_s2_r;
   logic        eo_s1_r, eo_s2_r, eo_d_r;
   logic        ext_osc_r;
   logic        ext_tick_r;
   logic        sda_out_r;

   gg_reg_if regs ();

   // Link reset: asserts at once, releases two link edges later
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         lrst_r <= 2'h0;
      end else begin
         lrst_r <= {lrst_r[0], 1'b1};
      end
   end
   wire logic link_rstn = lrst_r[1];

   // Clock enable carried into the link domain as a level
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         len_s1_r <= 1'b0;
         len_r    <= 1'b0;
      end else begin
         len_s1_r <= clk_en;
         len_r    <= len_s1_r;
      end
   end

   // Oversampled pins; no rate setting needed while link_clk is fast enough
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r  <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r  <= 1'b1;
      end else if (len_r) begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_d_r  <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_d_r  <= sda_s2_r;
      end
   end

   // Bus events; a data change with the clock high is a START or STOP
   wire logic scl_rise = scl_s2_r & ~scl_d_r;
   wire logic scl_fall = ~scl_s2_r & scl_d_r;
   wire logic ev_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   wire logic ev_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   // Phase decode
   wire logic in_rx    = state_r == gg_pkg::ST_RX;
   wire logic in_rack  = state_r == gg_pkg::ST_RACK;
   wire logic in_tx    = state_r == gg_pkg::ST_TX;
   wire logic in_tack  = state_r == gg_pkg::ST_TACK;
   wire logic rx_bit   = in_rx & scl_rise & (bit_cnt_r < gg_pkg::BITS_PER_BYTE);
   wire logic rx_end   = in_rx & scl_fall & (bit_cnt_r == gg_pkg::BITS_PER_BYTE);
   wire logic rack_end = in_rack & scl_fall;
   wire logic tx_fall  = in_tx & scl_fall;
   wire logic tx_last  = tx_fall & (bit_cnt_r == gg_pkg::BIT_LAST);
   wire logic tack_end = in_tack & scl_fall;

   // Byte classification and decisions at the end of a received byte
   wire logic id_match  = rx_sh_r[7:1] == gg_pkg::TARGET_BUS_ID;
   wire logic ptr_byte  = ~is_id_r & need_ptr_r;
   wire logic data_byte = ~is_id_r & ~need_ptr_r;
   wire logic [15:0] pair_word = {hi_r, rx_sh_r};
   wire logic wr_ok = (ptr_r <= gg_pkg::OFS_WRITE_TOP) | (ptr_r >= gg_pkg::OFS_RESET_CMD);
   wire logic por_cmd = data_byte & (ptr_r == gg_pkg::OFS_LAST) & hi_ok_r & ~past_top_r
                        & (pair_word == gg_pkg::FULL_RESET_VAL);
   wire logic ack_nxt = is_id_r ? id_match : ~por_cmd;
   wire logic commit  = rx_end & data_byte & ptr_r[0] & hi_ok_r & ~past_top_r & wr_ok;
   wire logic advance = (rx_end & data_byte) | tx_last;
   wire logic ptr_load = rx_end & ptr_byte;
   wire logic tx_load = (rack_end & ack_r & rw_r) | (tack_end & m_ack_r);
   wire logic [7:0] tx_byte = past_top_r ? gg_pkg::BYTE_PAST_TOP : fetch_r;

   // Next state; START wins from any state, so a repeated START restarts
   always_comb begin
      state_nxt = state_r;
      if (ev_start) begin
         state_nxt = gg_pkg::ST_RX;
      end else if (ev_stop) begin
         state_nxt = gg_pkg::ST_IDLE;
      end else begin
         unique case (state_r)
            gg_pkg::ST_IDLE: state_nxt = gg_pkg::ST_IDLE;
            gg_pkg::ST_RX: begin
               if (rx_end) begin
                  state_nxt = (is_id_r & ~id_match) ? gg_pkg::ST_IDLE
                                                    : gg_pkg::ST_RACK;
               end
            end
            gg_pkg::ST_RACK: begin
               if (rack_end) begin
                  state_nxt = ~ack_r ? gg_pkg::ST_IDLE :
                              rw_r   ? gg_pkg::ST_TX : gg_pkg::ST_RX;
               end
            end
            gg_pkg::ST_TX: begin
               if (tx_last) begin
                  state_nxt = gg_pkg::ST_TACK;
               end
            end
            gg_pkg::ST_TACK: begin
               if (tack_end) begin
                  state_nxt = m_ack_r ? gg_pkg::ST_TX : gg_pkg::ST_IDLE;
               end
            end
            default: state_nxt = gg_pkg::ST_IDLE;
         endcase
      end
   end

   // State register and bit counter
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         state_r   <= gg_pkg::ST_IDLE;
         bit_cnt_r <= 4'h0;
      end else if (len_r) begin
         state_r <= state_nxt;
         if (ev_start | rack_end | tack_end) begin
            bit_cnt_r <= 4'h0;
         end else if (rx_bit | tx_fall) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
      end
   end

   // Shift registers, MSB first both ways
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         rx_sh_r <= 8'h00;
         tx_sh_r <= 8'hff;
      end else if (len_r) begin
         if (rx_bit) begin
            rx_sh_r <= {rx_sh_r[6:0], sda_s2_r};
         end
         if (tx_load) begin
            tx_sh_r <= tx_byte;
         end else if (tx_fall) begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b1};
         end
      end
   end

   // Transaction flags: byte role, direction and acknowledge decisions
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         is_id_r    <= 1'b1;
         need_ptr_r <= 1'b1;
         rw_r       <= 1'b0;
         ack_r      <= 1'b0;
         m_ack_r    <= 1'b0;
      end else if (len_r) begin
         if (ev_start) begin
            is_id_r    <= 1'b1;
            need_ptr_r <= 1'b1;
         end else if (rx_end) begin
            is_id_r <= 1'b0;
            ack_r   <= ack_nxt;
            if (is_id_r) begin
               rw_r <= rx_sh_r[0];
            end else begin
               need_ptr_r <= 1'b0;
            end
         end
         if (in_tack & scl_rise) begin
            m_ack_r <= ~sda_s2_r;
         end
      end
   end

   // Byte pointer; it saturates into the past-top state after FFh
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         ptr_r      <= 8'h00;
         past_top_r <= 1'b0;
         rd_tgl_r   <= 1'b0;
      end else if (len_r) begin
         if (ptr_load) begin
            ptr_r      <= rx_sh_r;
            past_top_r <= 1'b0;
         end else if (advance) begin
            ptr_r      <= ptr_r + 8'h01;
            past_top_r <= past_top_r | (ptr_r == gg_pkg::OFS_LAST);
         end
         if (ptr_load | advance) begin
            rd_tgl_r <= ~rd_tgl_r;  // Prefetch the byte at the new pointer
         end
      end
   end

   // Word assembly: only a full high/low pair is handed over
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         hi_r      <= 8'h00;
         hi_ok_r   <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 16'h0000;
         wr_tgl_r  <= 1'b0;
      end else if (len_r) begin
         if (ev_start | ev_stop) begin
            hi_ok_r <= 1'b0;
         end else if (rx_end & data_byte) begin
            hi_r    <= rx_sh_r;
            hi_ok_r <= ~ptr_r[0];
         end
         if (commit) begin
            wr_addr_r <= {ptr_r[7:1], 1'b0};
            wr_data_r <= pair_word;
            wr_tgl_r  <= ~wr_tgl_r;
         end
      end
   end

   // Open-drain data drive: acknowledge low, data zeros low, else released
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         sda_oe_r <= 1'b0;
      end else if (len_r) begin
         if (ev_start | ev_stop) begin
            sda_oe_r <= 1'b0;
         end else if (rx_end) begin
            sda_oe_r <= ack_nxt;
         end else if (tx_load) begin
            sda_oe_r <= ~tx_byte[7];
         end else if (rack_end | tack_end) begin
            sda_oe_r <= 1'b0;
         end else if (tx_fall) begin
            sda_oe_r <= tx_last ? 1'b0 : ~tx_sh_r[6];
         end
      end
   end

   // Fetched read byte, taken when the main domain's answer toggles
   always_ff @(posedge link_clk or negedge link_rstn) begin
      if (!link_rstn) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         ack_d_r  <= 1'b0;
         fetch_r  <= gg_pkg::BYTE_UNMAPPED;
      end else if (len_r) begin
         ack_s1_r <= ack_tgl_r;
         ack_s2_r <= ack_s1_r;
         ack_d_r  <= ack_s2_r;
         if (ack_s2_r ^ ack_d_r) begin
            fetch_r <= rd_byte_m_r;
         end
      end
   end

   // Main side of the write handshake; link words are stable by now
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_s1_r     <= 1'b0;
         wr_s2_r     <= 1'b0;
         wr_d_r      <= 1'b0;
         wr_pulse_r  <= 1'b0;
         wr_addr_m_r <= 8'h00;
         wr_data_m_r <= 16'h0000;
      end else if (clk_en) begin
         wr_s1_r    <= wr_tgl_r;
         wr_s2_r    <= wr_s1_r;
         wr_d_r     <= wr_s2_r;
         wr_pulse_r <= wr_s2_r ^ wr_d_r;
         if (wr_s2_r ^ wr_d_r) begin
            wr_addr_m_r <= wr_addr_r;
            wr_data_m_r <= wr_data_r;
         end
      end
   end

   // Read fetch: latch pointer, let the bank select, then answer by toggle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_s1_r     <= 1'b0;
         rd_s2_r     <= 1'b0;
         rd_d_r      <= 1'b0;
         rd_pipe_r   <= 2'h0;
         rd_addr_m_r <= 8'h00;
         rd_byte_m_r <= gg_pkg::BYTE_UNMAPPED;
         ack_tgl_r   <= 1'b0;
      end else if (clk_en) begin
         rd_s1_r   <= rd_tgl_r;
         rd_s2_r   <= rd_s1_r;
         rd_d_r    <= rd_s2_r;
         rd_pipe_r <= {rd_pipe_r[0], rd_s2_r ^ rd_d_r};
         if (rd_s2_r ^ rd_d_r) begin
            rd_addr_m_r <= ptr_r;
         end
         if (rd_pipe_r[1]) begin
            rd_byte_m_r <= regs.rd_data;
            ack_tgl_r   <= ~ack_tgl_r;
         end
      end
   end

   // Strap and clock pin; edges are taken after the second stage only
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         osc_s1_r   <= 1'b0;
         osc_s2_r   <= 1'b0;
         eo_s1_r    <= 1'b0;
         eo_s2_r    <= 1'b0;
         eo_d_r     <= 1'b0;
         ext_osc_r  <= 1'b0;
         ext_tick_r <= 1'b0;
         sda_out_r  <= 1'b0;
      end else if (clk_en) begin
         osc_s1_r   <= osc_source_select_pin;
         osc_s2_r   <= osc_s1_r;
         eo_s1_r    <= ext_clock_or_restart_pin;
         eo_s2_r    <= eo_s1_r;
         eo_d_r     <= eo_s2_r;
         ext_osc_r  <= osc_s2_r;
         ext_tick_r <= osc_s2_r & eo_s2_r & ~eo_d_r;
         sda_out_r  <= 1'b0;  // Open drain only ever pulls low
      end
   end

   // Hardware quick-start request, one clock wide
   wire logic hw_quick = ~osc_s2_r & eo_s2_r & ~eo_d_r;

   assign regs.wr_pulse = wr_pulse_r;
   assign regs.wr_addr  = wr_addr_m_r;
   assign regs.wr_data  = wr_data_m_r;
   assign regs.rd_addr  = rd_addr_m_r;

   gg_reg_bank #(
      .REVISION_CODE (REVISION_CODE)
   ) u_bank (
      .clock              (clock),
      .rstn               (rstn),
      .clk_en             (clk_en),
      .regs               (regs.bank),
      .hw_quick_start     (hw_quick),
      .model_compensation (model_compensation),
      .quick_start        (quick_start),
      .full_reset         (full_reset)
   );

   assign sda_out          = sda_out_r;
   assign sda_oe           = sda_oe_r;
   assign ext_osc_selected = ext_osc_r;
   assign ext_clock_tick   = ext_tick_r;

endmodule // gg_gauge_target
`default_nettype wire

//--- core/gg_pkg.sv
// Package: constants, offsets and state codes of the gauge two-wire target
package gg_pkg;

   // Fixed 7-bit target identity on the two-wire bus
   localparam logic [6:0]  TARGET_BUS_ID    = 7'h36;

   // Byte addresses of the register map (high byte at the even address)
   localparam logic [7:0]  OFS_SPECIAL_MODE = 8'h06;
   localparam logic [7:0]  OFS_REVISION     = 8'h08;
   localparam logic [7:0]  OFS_MODEL_COMP   = 8'h0c;
   localparam logic [7:0]  OFS_RESET_CMD    = 8'hfe;
   localparam logic [7:0]  OFS_WRITE_TOP    = 8'h4f;
   localparam logic [7:0]  OFS_LAST         = 8'hff;

   // Command words and values after reset
   localparam logic [15:0] QUICK_START_VAL  = 16'h4000;
   localparam logic [15:0] FULL_RESET_VAL   = 16'h0054;
   localparam logic [15:0] MODEL_COMP_RESET = 16'h9700;

   // Bytes returned where no register stands
   localparam logic [7:0]  BYTE_PAST_TOP    = 8'hff;
   localparam logic [7:0]  BYTE_UNMAPPED    = 8'h00;

   // Bit counts of one byte on the wire
   localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
   localparam logic [3:0]  BIT_LAST         = 4'h7;

   // Link engine states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX   = 5'h02,
      ST_RACK = 5'h04,
      ST_TX   = 5'h08,
      ST_TACK = 5'h10
   } gg_link_state_type;

endpackage

//--- core/gg_reg_bank.sv
// Module: gauge registers, command decode and read byte selection
`timescale 1ns/1ns
`default_nettype none
module gg_reg_bank #(
   parameter logic [15:0] REVISION_CODE = 16'h0001  // Arbitrary value
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        clk_en,
   gg_reg_if.bank           regs,
   input  wire logic        hw_quick_start,
   output logic [15:0]      model_compensation,
   output logic             quick_start,
   output logic             full_reset
);

   // High byte sits at the even address
   function automatic logic [7:0] pick_byte(input logic lsb, input logic [15:0] w);
      return lsb ? w[7:0] : w[15:8];
   endfunction

   logic [15:0] model_comp_r;
   logic        quick_start_r;
   logic        full_reset_r;
   logic [7:0]  rd_data_r;

   // Command decode; any other word is accepted and dropped
   wire logic hit_mode  = regs.wr_pulse & (regs.wr_addr == gg_pkg::OFS_SPECIAL_MODE);
   wire logic hit_cmd   = regs.wr_pulse & (regs.wr_addr == gg_pkg::OFS_RESET_CMD);
   wire logic hit_comp  = regs.wr_pulse & (regs.wr_addr == gg_pkg::OFS_MODEL_COMP);
   wire logic do_quick  = hit_mode & (regs.wr_data == gg_pkg::QUICK_START_VAL);
   wire logic do_reset  = hit_cmd & (regs.wr_data == gg_pkg::FULL_RESET_VAL);
   wire logic [6:0] rd_word = regs.rd_addr[7:1];
   wire logic [7:0] rd_sel  =
      (rd_word == gg_pkg::OFS_MODEL_COMP[7:1]) ? pick_byte(regs.rd_addr[0], model_comp_r) :
      (rd_word == gg_pkg::OFS_REVISION[7:1])   ? pick_byte(regs.rd_addr[0], REVISION_CODE) :
      gg_pkg::BYTE_UNMAPPED;

   // Compensation word; a full reset brings back the factory value
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         model_comp_r <= gg_pkg::MODEL_COMP_RESET;
      end else if (clk_en) begin
         if (do_reset) begin
            model_comp_r <= gg_pkg::MODEL_COMP_RESET;
         end else if (hit_comp) begin
            model_comp_r <= regs.wr_data;
         end
      end
   end

   // One-cycle command pulses and registered read byte
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         quick_start_r <= 1'b0;
         full_reset_r  <= 1'b0;
         rd_data_r     <= gg_pkg::BYTE_UNMAPPED;
      end else if (clk_en) begin
         quick_start_r <= do_quick | hw_quick_start;
         full_reset_r  <= do_reset;
         rd_data_r     <= rd_sel;
      end
   end

   assign model_compensation = model_comp_r;
   assign quick_start        = quick_start_r;
   assign full_reset         = full_reset_r;
   assign regs.rd_data       = rd_data_r;

endmodule // gg_reg_bank
`default_nettype wire

//--- core/gg_reg_if.sv
// Interface: register access between the bus engine and the register bank
`timescale 1ns/1ns
`default_nettype none
interface gg_reg_if;
   logic        wr_pulse;
   logic [7:0]  wr_addr;
   logic [15:0] wr_data;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_data;

   modport engine (output wr_pulse, output wr_addr, output wr_data, output rd_addr,
                   input rd_data);
   modport bank   (input wr_pulse, input wr_addr, input wr_data, input rd_addr,
                   output rd_data);
endinterface
`default_nettype wire

//--- test/gg_bus_host.sv
// Bus master model driving the two-wire pins of the gauge target
`timescale 1ns/1ns
`default_nettype none
module gg_bus_host (
   input  wire logic clock,
   input  wire logic sda_oe,
   output logic      scl_in,
   output logic      sda_in
);
   logic sda_m_r = 1'b1;
   initial scl_in = 1'b1;
   // Pullup: line reads high unless a party pulls it low
   assign sda_in = sda_m_r & ~sda_oe;
   task automatic q(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Low 28 cycles, high 24: about 385 kHz, low phase above 1.3 us
   task automatic bit_io(input logic b, output logic r);
      sda_m_r <= b;
      q(14);
      scl_in <= 1'b1;
      q(24);
      r = sda_in;
      scl_in <= 1'b0;
      q(14);
   endtask
   // START when s is high (repeated too), STOP otherwise
   task automatic cond(input logic s);
      sda_m_r <= s;
      q(14);
      scl_in <= 1'b1;
      q(14);
      sda_m_r <= !s;
      q(14);
      if (s) begin
         scl_in <= 1'b0;
         q(14);
      end
   endtask
   task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r,
                       output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(ak, a);
   endtask
endmodule // gg_bus_host
`default_nettype wire

//--- test/gg_gauge_target_tb.sv
// Self-checking bench of the gauge two-wire target
`timescale 1ns/1ns
`default_nettype none
module gg_gauge_target_tb;
   logic        clock = 1'b0, link_clk = 1'b0, rstn, clk_en;
   logic        osc_source_select_pin, ext_clock_or_restart_pin;
   logic        scl_in, sda_in, sda_out, sda_oe, quick_start, full_reset, a;
   logic        ext_osc_selected, ext_clock_tick;
   logic [15:0] model_compensation, v;
   logic [7:0]  r;
   int          n_fail = 0, total_checks = 0, n_qs = 0, n_fr = 0, n_tk = 0, cyc = 0;
   // Rows: write flag, pointer, word written, word read back
   localparam logic [40:0] ROWS [5] = '{{1'b0, 8'h0c, 16'h0000, 16'h9700},
      {1'b1, 8'h0c, 16'h1234, 16'h1234}, {1'b1, 8'h08, 16'h5555, 16'h0001},
      {1'b1, 8'h06, 16'h1111, 16'h0000}, {1'b1, 8'h50, 16'habcd, 16'h0000}};
   always #25 clock = ~clock;
   // Link clock offset so its phase is unrelated to the main clock
   initial begin
      #7;
      forever #40 link_clk = ~link_clk;
   end
   gg_gauge_target gg_gauge_target_i (.*);
   gg_bus_host gg_bus_host_i (.*);
   task automatic stop_test();
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Pulse counters and hang guard
   always @(posedge clock) begin
      n_qs <= n_qs + int'(quick_start === 1'b1);
      n_fr <= n_fr + int'(full_reset === 1'b1);
      n_tk <= n_tk + int'(ext_clock_tick === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         $display("[ERR] %0t timeout", $time);
         stop_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One byte from master; ea is the answer expected (0 = acknowledge)
   task automatic tx(input logic [7:0] d, input logic ea);
      gg_bus_host_i.xfer(d, 1'b1, r, a);
      chk(a, ea);
   endtask
   task automatic wr16(input logic [7:0] p, input logic [15:0] d, input logic ea);
      gg_bus_host_i.cond(1'b1);
      tx(8'h6c, 1'b0);
      tx(p, 1'b0);
      tx(d[15:8], 1'b0);
      tx(d[7:0], ea);
      gg_bus_host_i.cond(1'b0);
   endtask
   task automatic rd16(input logic [7:0] p);
      gg_bus_host_i.cond(1'b1);
      tx(8'h6c, 1'b0);
      tx(p, 1'b0);
      gg_bus_host_i.cond(1'b1);
      tx(8'h6d, 1'b0);
      gg_bus_host_i.xfer(8'hff, 1'b0, v[15:8], a);
      gg_bus_host_i.xfer(8'hff, 1'b1, v[7:0], a);
      gg_bus_host_i.cond(1'b0);
   endtask
   initial begin
      // Inputs start by the bench's own drive, so every one is a real stimulus
      rstn                     <= 1'b0;
      clk_en                   <= 1'b1;
      osc_source_select_pin    <= 1'b0;
      ext_clock_or_restart_pin <= 1'b0;
      repeat (10) @(posedge clock);
      chk(model_compensation, 16'h9700);
      chk(sda_oe, 1'b0);
      rstn <= 1'b1;
      repeat (20) @(posedge clock);
      for (int i = 0; i < 5; i++) begin
         if (ROWS[i][40]) wr16(ROWS[i][39:32], ROWS[i][31:16], 1'b0);
         rd16(ROWS[i][39:32]);
         chk(v, ROWS[i][15:0]);
      end
      chk(16'(n_qs), 16'h0000);
      // Foreign address, then a lone high byte dropped at STOP
      gg_bus_host_i.cond(1'b1);
      tx(8'h6e, 1'b1);
      gg_bus_host_i.cond(1'b0);
      gg_bus_host_i.cond(1'b1);
      tx(8'h6c, 1'b0);
      tx(8'h0c, 1'b0);
      tx(8'h55, 1'b0);
      gg_bus_host_i.cond(1'b0);
      chk(model_compensation, 16'h1234);
      wr16(8'h06, 16'h4000, 1'b0);
      repeat (10) @(posedge clock);
      chk(16'(n_qs), 16'h0001);
      ext_clock_or_restart_pin <= 1'b1;
      repeat (10) @(posedge clock);
      chk(16'(n_qs), 16'h0002);
      // Reset byte goes unanswered and restores the compensation word
      wr16(8'hfe, 16'h0054, 1'b1);
      repeat (10) @(posedge clock);
      chk(model_compensation, 16'h9700);
      chk(16'(n_fr), 16'h0001);
      rd16(8'hff);
      chk(v, 16'h00ff);
      // Frozen enable: engine deaf, probe unanswered; answered again once running
      clk_en <= 1'b0;
      repeat (10) @(posedge clock);
      gg_bus_host_i.cond(1'b1);
      tx(8'h6c, 1'b1);
      gg_bus_host_i.cond(1'b0);
      clk_en <= 1'b1;
      repeat (20) @(posedge clock);
      gg_bus_host_i.cond(1'b1);
      tx(8'h6c, 1'b0);
      gg_bus_host_i.cond(1'b0);
      chk(model_compensation, 16'h9700);
      // Select high: three rises of a 32 kHz clock give ticks, no restart
      osc_source_select_pin <= 1'b1;
      repeat (10) @(posedge clock);
      chk(ext_osc_selected, 1'b1);
      repeat (6) begin
         repeat (312) @(posedge clock);
         ext_clock_or_restart_pin <= ~ext_clock_or_restart_pin;
      end
      repeat (10) @(posedge clock);
      chk(16'(n_tk), 16'h0003);
      chk(16'(n_qs), 16'h0002);
      stop_test();
   end
endmodule // gg_gauge_target_tb
`default_nettype wire

//--- test/gg_target_checker.sv
// Checker: port-level properties of the gauge two-wire target
`timescale 1ns/1ns
`default_nettype none
module gg_target_checker (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        scl_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        osc_source_select_pin,
   input wire logic        ext_clock_or_restart_pin,
   input wire logic [15:0] model_compensation,
   input wire logic        quick_start,
   input wire logic        full_reset,
   input wire logic        ext_osc_selected,
   input wire logic        ext_clock_tick
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Pin edges, split by strap state
   sequence hw_edge_s;
      $rose(ext_clock_or_restart_pin) && !osc_source_select_pin && !ext_osc_selected;
   endsequence
   sequence ext_edge_s;
      $rose(ext_clock_or_restart_pin) && osc_source_select_pin && ext_osc_selected;
   endsequence
   od_drive_a:  assert property (sda_oe |-> !sda_out) else $error("sda high");
   qs_pulse_a:  assert property (quick_start |=> !quick_start) else $error("qs");
   fr_pulse_a:  assert property (full_reset |=> !full_reset) else $error("fr");
   fr_restore_a: assert property (full_reset |-> ##[0:2]
      model_compensation == gg_pkg::MODEL_COMP_RESET) else $error("comp");
   sel_follow_a: assert property ($stable(osc_source_select_pin) [*4] |->
      ext_osc_selected == osc_source_select_pin) else $error("sel");
   tick_edge_a: assert property (ext_edge_s |-> ##[2:6] ext_clock_tick) else $error("tk");
   hw_qs_a:     assert property (hw_edge_s |-> ##[2:6] quick_start) else $error("hw");
   // Device moves SDA only while SCL is low
   oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("oe");
endmodule // gg_target_checker
bind gg_gauge_target gg_target_checker gg_target_checker_i (.*);
`default_nettype wire
